// ==== src/lfs_pkg.sv ====
// constants and types shared by the led string fault sequencer
package lfs_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_NS   = 10;
    localparam int ON_NS    = 3000;
    localparam int OFF_NS   = 500;
    localparam int ON_CYC   = ON_NS / CLK_NS;
    localparam int OFF_CYC  = OFF_NS / CLK_NS;
    localparam int DLY_W    = 9;
    localparam logic [DLY_W-1:0] ON_LAST  = DLY_W'(ON_CYC - 1);
    localparam logic [DLY_W-1:0] OFF_LAST = DLY_W'(OFF_CYC - 1);
    localparam int TMO_DEF  = 131072;
    localparam int TMO_W    = 18;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] A_STATUS  = 8'h00;
    localparam logic [7:0] A_IRQ_EN  = 8'h04;
    localparam logic [7:0] A_IRQ_CLR = 8'h08;
    localparam logic [7:0] A_STATE   = 8'h0C;
    localparam int NEV        = 7;
    localparam int EV_SHDN    = 0;
    localparam int EV_DISC    = 1;
    localparam int EV_SHORT   = 2;
    localparam int EV_THERM   = 3;
    localparam int EV_SOVP    = 4;
    localparam int EV_OPEN    = 5;
    localparam int EV_SSDONE  = 6;
    localparam logic [NEV-1:0] RST_IRQ_EN = 7'h00;

    // ************************************************************
    // synchronised pin positions
    // ************************************************************
    localparam int P_EN    = 0;
    localparam int P_SUP   = 1;
    localparam int P_SELL  = 2;
    localparam int P_SELH  = 3;
    localparam int P_ABOVE = 4;
    localparam int P_OVP   = 8;
    localparam int P_SHORT = 9;
    localparam int P_THERM = 13;
    localparam int P_SOVP  = 14;
    localparam int P_DOC   = 15;
    localparam int P_D3V   = 16;
    localparam int P_CLOCK = 17;
    localparam int P_CGND  = 18;
    localparam int NPIN    = 19;

    typedef enum logic [4:0] {
        ST_OFF   = 5'h01,
        ST_SOFT  = 5'h02,
        ST_RUN   = 5'h04,
        ST_DISCH = 5'h08,
        ST_LATCH = 5'h10
    } lfs_state_t;

endpackage : lfs_pkg

// ==== src/lfs_pin_sync.sv ====
// three-stage pin synchroniser, output moves once stages two and three agree
`timescale 1ns/1ns
module lfs_pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] lvl_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } lfs_sync_t;

    lfs_sync_t st;
    lfs_sync_t next_st;

    always_comb
    begin
        next_st    = st;
        next_st.s1 = pin_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.q  = (~(st.s2 ^ st.s3) & st.s2) | ((st.s2 ^ st.s3) & st.q);
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign lvl_o = st.q;

    chk_sync_agree : assert property (@(posedge clk_i) disable iff (srst_i)
        (st.s2 == st.s3) |=> (st.q == $past(st.s2)))
        else $error("sync output ignored agreeing stages");

endmodule : lfs_pin_sync

// ==== src/lfs_low_timer.sv ====
// counts one continuous low interval of the enable level
`timescale 1ns/1ns
module lfs_low_timer
    import lfs_pkg::*;
#(
    parameter int LIMIT = TMO_DEF
) (
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic en_lvl_i,
    output logic      expired_o
);
    localparam logic [TMO_W-1:0] LIM   = TMO_W'(LIMIT);
    localparam logic [TMO_W-1:0] SATUR = TMO_W'(LIMIT + 1);

    typedef struct packed {
        logic [TMO_W-1:0] cnt;
        logic             exp;
    } lfs_tmr_t;

    lfs_tmr_t st;
    lfs_tmr_t next_st;

    always_comb
    begin
        next_st     = st;
        next_st.exp = 1'b0;
        if (en_lvl_i)
            next_st.cnt = '0;
        else if (st.cnt != SATUR)
        begin
            next_st.cnt = st.cnt + 18'h00001;
            next_st.exp = (st.cnt == LIM);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign expired_o = st.exp;

    chk_count_restart : assert property (@(posedge clk_i) disable iff (srst_i)
        en_lvl_i |=> (st.cnt == '0 && !st.exp))
        else $error("low counter not restarted by high enable");

endmodule : lfs_low_timer

// ==== src/lfs_sequencer.sv ====
// enable, soft-start and fault-latch sequencer for a four-string led driver
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
// Behaviour
// - enable low for more than 131072 clock cycles puts the block in shutdown.
// - entering shutdown clears every latched fault and the regulation lockout.
// - a rising enable brings the string current on about 3 us later.
// - a falling enable takes the string current off about 0.5 us later.
// - soft start limits boost peak current and runs strings at a twentieth.
// - soft start ends only when every enabled string pin is above threshold.
// - the compensation node is held low throughout soft start.
// - with enable already high, start waits for the supply to be good.
// - disconnect overcurrent latches the switch off; boost stops above 3 V.
// - compensation lockout turns the sinks off and discharges the node.
// - compensation at ground returns to soft start with the latch still set.
// - an overvoltage trip removes unregulated strings from loop control.
// - a short from output to a string pin latches boost and sinks off.
// - the two select inputs enable one, two, three or four strings.
// - short enable lows keep the lockout; every overvoltage retests all.
module lfs_sequencer
    import lfs_pkg::*;
#(
    parameter int TMO_CYC = TMO_DEF
) (
    input  wire logic        CLK_I,
    input  wire logic        SRST_I,
    input  wire logic        ENABLE_I,
    input  wire logic        SUPPLY_OK_I,
    input  wire logic        STRING_SELECT_LOW_I,
    input  wire logic        STRING_SELECT_HIGH_I,
    input  wire logic [3:0]  STRING_ABOVE_I,
    input  wire logic        OUTPUT_OVERVOLTAGE_TRIP_I,
    input  wire logic [3:0]  STRING_SHORT_I,
    input  wire logic        THERMAL_SHUTDOWN_FAULT_I,
    input  wire logic        SECONDARY_OVP_I,
    input  wire logic        DISC_OVERCURRENT_I,
    input  wire logic        DISC_OVER_3V_I,
    input  wire logic        COMP_LOCKOUT_I,
    input  wire logic        COMP_AT_GROUND_I,
    input  wire logic [7:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic [31:0]      RDATA_O,
    output logic             IRQ_O,
    output logic             BOOST_EN_O,
    output logic             BOOST_SS_LIMIT_O,
    output logic [3:0]       SINK_EN_O,
    output logic             SINK_SS_O,
    output logic             COMP_CLAMP_O,
    output logic             DISC_SW_ON_O,
    output logic [3:0]       REG_LOCK_O
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        lfs_state_t       state;
        logic [DLY_W-1:0] dly;
        logic             sink_on;
        logic             en_d;
        logic             ovp_d;
        logic [3:0]       reg_lock;
        logic             disc_latch;
        logic             short_l;
        logic             therm_l;
        logic             sovp_l;
        logic [NEV-1:0]   status;
        logic [NEV-1:0]   irq_en;
        logic [31:0]      rdata;
        logic             irq;
        logic             boost_en;
        logic             ss_lim;
        logic [3:0]       sink_en;
        logic             sink_ss;
        logic             comp_clamp;
        logic             disc_on;
    } lfs_seq_t;

    lfs_seq_t st;
    lfs_seq_t next_st;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s;
    logic            tmo_exp;
    logic            en_s;
    logic            sup_s;
    logic [3:0]      above_s;
    logic [3:0]      short_s;
    logic            ovp_s;
    logic            therm_s;
    logic            sovp_s;
    logic            doc_s;
    logic            d3v_s;
    logic            clock_s;
    logic            cgnd_s;
    logic [3:0]      sel_mask;
    logic [3:0]      str_ok;
    logic            ss_done;
    logic            active;
    logic            next_active;
    logic [NEV-1:0]  ev;
    logic [NEV-1:0]  clr;

    // ************************************************************
    // pin synchronisers and low timer
    // ************************************************************
    assign pin_raw = {COMP_AT_GROUND_I, COMP_LOCKOUT_I, DISC_OVER_3V_I,
                      DISC_OVERCURRENT_I, SECONDARY_OVP_I,
                      THERMAL_SHUTDOWN_FAULT_I, STRING_SHORT_I,
                      OUTPUT_OVERVOLTAGE_TRIP_I, STRING_ABOVE_I,
                      STRING_SELECT_HIGH_I, STRING_SELECT_LOW_I,
                      SUPPLY_OK_I, ENABLE_I};

    lfs_pin_sync #(
        .W (NPIN)
    ) u_sync (
        .clk_i  (CLK_I),
        .srst_i (SRST_I),
        .pin_i  (pin_raw),
        .lvl_o  (pin_s)
    );

    lfs_low_timer #(
        .LIMIT (TMO_CYC)
    ) u_timer (
        .clk_i     (CLK_I),
        .srst_i    (SRST_I),
        .en_lvl_i  (en_s),
        .expired_o (tmo_exp)
    );

    assign en_s    = pin_s[P_EN];
    assign sup_s   = pin_s[P_SUP];
    assign above_s = pin_s[P_ABOVE +: 4];
    assign ovp_s   = pin_s[P_OVP];
    assign short_s = pin_s[P_SHORT +: 4];
    assign therm_s = pin_s[P_THERM];
    assign sovp_s  = pin_s[P_SOVP];
    assign doc_s   = pin_s[P_DOC];
    assign d3v_s   = pin_s[P_D3V];
    assign clock_s = pin_s[P_CLOCK];
    assign cgnd_s  = pin_s[P_CGND];

    // ************************************************************
    // string selection
    // ************************************************************
    always_comb
    begin
        case ({pin_s[P_SELH], pin_s[P_SELL]})
            2'b00:   sel_mask = 4'h1;
            2'b01:   sel_mask = 4'h3;
            2'b10:   sel_mask = 4'h7;
            2'b11:   sel_mask = 4'hF;
            default: sel_mask = 4'h1;
        endcase
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_str
            assign str_ok[gi] = ~sel_mask[gi] | above_s[gi];
        end
    endgenerate

    assign ss_done = &str_ok;
    assign active  = (st.state == ST_SOFT) || (st.state == ST_RUN);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        next_st       = st;
        next_st.rdata = '0;
        next_st.en_d  = en_s;
        next_st.ovp_d = ovp_s;
        ev            = '0;
        clr           = '0;

        // dimming on and off delays
        if (!active || en_s != st.en_d)
            next_st.dly = '0;
        else if (en_s && !st.sink_on)
        begin
            next_st.dly = st.dly + 9'h001;
            if (st.dly == ON_LAST)
            begin
                next_st.sink_on = 1'b1;
                next_st.dly     = '0;
            end
        end
        else if (!en_s && st.sink_on)
        begin
            next_st.dly = st.dly + 9'h001;
            if (st.dly == OFF_LAST)
            begin
                next_st.sink_on = 1'b0;
                next_st.dly     = '0;
            end
        end

        case (st.state)
            ST_OFF:
            begin
                next_st.sink_on = 1'b0;
                if (en_s && sup_s)
                    next_st.state = ST_SOFT;
            end
            ST_SOFT, ST_RUN:
            begin
                if (!sup_s)
                    next_st.state = ST_OFF;
                else if (|short_s || therm_s || sovp_s)
                begin
                    next_st.state   = ST_LATCH;
                    next_st.short_l = st.short_l | (|short_s);
                    next_st.therm_l = st.therm_l | therm_s;
                    next_st.sovp_l  = st.sovp_l | sovp_s;
                    ev[EV_SHORT]    = |short_s;
                    ev[EV_THERM]    = therm_s;
                    ev[EV_SOVP]     = sovp_s;
                end
                else if (clock_s)
                    next_st.state = ST_DISCH;
                else if (st.state == ST_SOFT && ss_done)
                begin
                    next_st.state  = ST_RUN;
                    ev[EV_SSDONE]  = 1'b1;
                end
                if (doc_s && !st.disc_latch)
                begin
                    next_st.disc_latch = 1'b1;
                    ev[EV_DISC]        = 1'b1;
                end
                if (ovp_s && !st.ovp_d)
                begin
                    next_st.reg_lock = sel_mask & ~above_s;
                    ev[EV_OPEN]      = |(sel_mask & ~above_s);
                end
            end
            ST_DISCH:
            begin
                next_st.sink_on = 1'b0;
                if (cgnd_s)
                    next_st.state = ST_SOFT;
            end
            ST_LATCH:
            begin
                next_st.sink_on = 1'b0;
            end
            default:
            begin
                next_st.state = ST_OFF;
            end
        endcase

        // long enable low wins over every other condition
        if (tmo_exp)
        begin
            next_st.state      = ST_OFF;
            next_st.sink_on    = 1'b0;
            next_st.disc_latch = 1'b0;
            next_st.short_l    = 1'b0;
            next_st.therm_l    = 1'b0;
            next_st.sovp_l     = 1'b0;
            next_st.reg_lock   = '0;
            ev[EV_SHDN]        = 1'b1;
        end

        // register port
        if (WR_I && ADDR_I == A_IRQ_EN)
            next_st.irq_en = WDATA_I[NEV-1:0];
        if (WR_I && ADDR_I == A_IRQ_CLR)
            clr = WDATA_I[NEV-1:0];
        if (RD_I)
        begin
            case (ADDR_I)
                A_STATUS:  next_st.rdata = {25'h0000000, st.status};
                A_IRQ_EN:  next_st.rdata = {25'h0000000, st.irq_en};
                A_STATE:   next_st.rdata = {19'h00000, st.disc_latch,
                                            st.short_l, st.therm_l,
                                            st.sovp_l, st.reg_lock,
                                            st.state};
                default:   next_st.rdata = '0;
            endcase
        end
        next_st.status = (st.status & ~clr) | ev;
        next_st.irq    = |(next_st.status & next_st.irq_en);

        // outputs follow the next state
        next_active        = (next_st.state == ST_SOFT) ||
                             (next_st.state == ST_RUN);
        next_st.boost_en   = next_active && en_s &&
                             !(next_st.disc_latch && d3v_s);
        next_st.ss_lim     = (next_st.state == ST_SOFT);
        next_st.sink_ss    = (next_st.state == ST_SOFT);
        next_st.sink_en    = (next_active && next_st.sink_on) ?
                             sel_mask : 4'h0;
        next_st.comp_clamp = (next_st.state == ST_SOFT) ||
                             (next_st.state == ST_DISCH);
        next_st.disc_on    = next_active && !next_st.disc_latch;
    end

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            st        <= '0;
            st.state  <= ST_OFF;
            st.irq_en <= RST_IRQ_EN;
        end
        else
            st <= next_st;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign RDATA_O          = st.rdata;
    assign IRQ_O            = st.irq;
    assign BOOST_EN_O       = st.boost_en;
    assign BOOST_SS_LIMIT_O = st.ss_lim;
    assign SINK_EN_O        = st.sink_en;
    assign SINK_SS_O        = st.sink_ss;
    assign COMP_CLAMP_O     = st.comp_clamp;
    assign DISC_SW_ON_O     = st.disc_on;
    assign REG_LOCK_O       = st.reg_lock;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);

    sequence s_lock_hit;
        active && sup_s && !(|short_s) && !therm_s && !sovp_s && clock_s
            && !tmo_exp;
    endsequence

    sequence s_disch_out;
        st.state == ST_DISCH && !st.comp_clamp == 1'b0 && st.sink_en == 4'h0;
    endsequence

    chk_shutdown_entry : assert property (tmo_exp |=> st.state == ST_OFF)
        else $error("timeout did not force shutdown");

    chk_fault_clear : assert property (
        tmo_exp |=> (!st.disc_latch && !st.short_l && !st.therm_l
                     && !st.sovp_l && st.reg_lock == 4'h0))
        else $error("shutdown left a fault latched");

    chk_turn_on_delay : assert property (
        $rose(st.sink_on) |-> ($past(st.dly) == ON_LAST && $past(en_s)))
        else $error("string current came on at the wrong time");

    chk_turn_off_delay : assert property (
        $fell(st.sink_on) && $past(active) && !$past(tmo_exp)
            && $past(st.state) == st.state
        |-> ($past(st.dly) == OFF_LAST && !$past(en_s)))
        else $error("string current went off at the wrong time");

    chk_soft_outputs : assert property (
        st.state == ST_SOFT |-> (st.ss_lim && st.sink_ss))
        else $error("soft start limits not applied");

    chk_soft_exit : assert property (
        st.state == ST_SOFT && $past(st.state) == ST_RUN |-> 1'b0)
        else $error("returned from run to soft start directly");

    chk_soft_ready : assert property (
        st.state == ST_RUN && $past(st.state) == ST_SOFT |-> $past(ss_done))
        else $error("soft start ended before strings were above threshold");

    chk_comp_clamp : assert property (
        st.state == ST_SOFT |-> st.comp_clamp)
        else $error("compensation released during soft start");

    chk_supply_wait : assert property (
        st.state == ST_OFF && !sup_s && !tmo_exp |=> st.state == ST_OFF)
        else $error("started before supply was good");

    chk_disc_latch : assert property (
        active && doc_s && !tmo_exp |=> (st.disc_latch && !st.disc_on))
        else $error("disconnect switch not latched off");

    chk_comp_lockout : assert property (
        s_lock_hit |=> s_disch_out)
        else $error("lockout did not discharge and stop the sinks");

    chk_disch_return : assert property (
        st.state == ST_DISCH && cgnd_s && !tmo_exp
        |=> (st.state == ST_SOFT && st.disc_latch == $past(st.disc_latch)))
        else $error("discharge did not return to soft start");

    chk_open_retest : assert property (
        active && ovp_s && !st.ovp_d && !tmo_exp
        |=> st.reg_lock == $past(sel_mask & ~above_s))
        else $error("overvoltage did not retest the strings");

    chk_short_latch : assert property (
        active && sup_s && (|short_s) && !tmo_exp
        |=> (st.state == ST_LATCH && !st.boost_en && st.sink_en == 4'h0))
        else $error("string short did not latch the block off");

    chk_select_map : assert property (
        st.sink_en != 4'h0 |-> (st.sink_en[0] && (st.sink_en[3] -> st.sink_en[2])
                                && (st.sink_en[2] -> st.sink_en[1])))
        else $error("string enables break the select table");

    chk_lock_hold : assert property (
        !tmo_exp && !(ovp_s && !st.ovp_d) |=> $stable(st.reg_lock))
        else $error("regulation lockout changed without cause");

endmodule : lfs_sequencer

// ==== tb/lfs_host_model.sv ====
// host controller model driving the enable and dimming pin
`timescale 1ns/1ns
module lfs_host_model (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        hold_i,
    input  wire logic        go_i,
    input  wire logic [17:0] low_len_i,
    output logic             en_o
);
    logic [17:0] cnt;

    // ********
    // dimming low period
    // ********
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            cnt <= 18'h0;
        else if (go_i)
            cnt <= low_len_i;
        else if (cnt != 18'h0)
            cnt <= cnt - 18'h1;
    end

    // a low longer than the timeout clears device latches before enable rises again
    assign en_o = !hold_i && (cnt == 18'h0);
endmodule : lfs_host_model

// ==== tb/tb_top.sv ====
// self-checking bench for the led string fault sequencer
`timescale 1ns/1ns
module tb_top;
    import lfs_pkg::*;
    localparam int TMO = 200;
    logic        clk = 1'b0, srst = 1'b1, hold = 1'b1, go = 1'b0, en, sup = 1'b0;
    logic        sel_l = 1'b0, sel_h = 1'b0, output_overvoltage_trip = 1'b0, doc = 1'b0, d3v = 1'b0;
    logic        lock = 1'b0, cgnd = 1'b0, wr = 1'b0, rd = 1'b0;
    logic        irq, boost, ss_lim, sink_ss, clamp, disc;
    logic [2:0]  flt = 3'h0;
    logic [3:0]  above = 4'h0, sink, rlock;
    logic [7:0]  addr = 8'h00;
    logic [17:0] len = 18'h0;
    logic [31:0] wdata = 32'h0, rdata;
    int          num_errors = 0, checks = 0, cycles = 0;

    always #5 clk = ~clk;

    lfs_host_model host (.clk_i(clk), .srst_i(srst), .hold_i(hold), .go_i(go),
        .low_len_i(len), .en_o(en));
    lfs_sequencer #(.TMO_CYC(TMO)) dut (
        .CLK_I(clk), .SRST_I(srst), .ENABLE_I(en), .SUPPLY_OK_I(sup),
        .STRING_SELECT_LOW_I(sel_l), .STRING_SELECT_HIGH_I(sel_h), .STRING_ABOVE_I(above),
        .OUTPUT_OVERVOLTAGE_TRIP_I(output_overvoltage_trip), .STRING_SHORT_I({3'h0, flt[0]}),
        .THERMAL_SHUTDOWN_FAULT_I(flt[1]), .SECONDARY_OVP_I(flt[2]),
        .DISC_OVERCURRENT_I(doc), .DISC_OVER_3V_I(d3v), .COMP_LOCKOUT_I(lock),
        .COMP_AT_GROUND_I(cgnd), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .IRQ_O(irq), .BOOST_EN_O(boost), .BOOST_SS_LIMIT_O(ss_lim),
        .SINK_EN_O(sink), .SINK_SS_O(sink_ss), .COMP_CLAMP_O(clamp), .DISC_SW_ON_O(disc),
        .REG_LOCK_O(rlock));

    // ********
    // tasks
    // ********
    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                          input string n);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(n, e, rdata & m);
    endtask : rd_reg

    task automatic pulse(input int n);
        @(posedge clk);
        len <= 18'(n);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask : pulse

    // long low, state read after the timeout, returns as enable rises
    task automatic shut();
        pulse(TMO + 40);
        cyc(TMO + 15);
        rd_reg(A_STATE, 32'h1FFF, 32'h01, "state_off");
        cyc(23);
    endtask : shut

    task automatic run_sel(input int s);
        logic [3:0] m;
        m = 4'((1 << (s + 1)) - 1);
        {sel_h, sel_l} <= 2'(s);
        above <= ~m;
        shut();
        cyc(295);
        chk("sink_early", 0, sink);
        cyc(15);
        chk("sink_on", m, sink);
        chk("soft", 3'b111, {ss_lim, sink_ss, clamp});
        above <= m;
        cyc(8);
        chk("run", 0, {ss_lim, sink_ss, clamp});
        pulse(150);
        cyc(45);
        chk("sink_hold", m, sink);
        cyc(15);
        chk("sink_off", 0, sink);
        cyc(100);
        pulse(150);
        cyc(160);
        rd_reg(A_STATE, 32'h1F, 32'h04, "state_run");
    endtask : run_sel

    // ********
    // sequence
    // ********
    initial
    begin
        cyc(20);
        srst <= 1'b0;
        rd_reg(A_STATUS, 32'hFFFFFFFF, 32'h0, "status_rst");
        rd_reg(A_IRQ_EN, 32'hFFFFFFFF, 32'h0, "irq_en_rst");
        rd_reg(8'h10, 32'hFFFFFFFF, 32'h0, "unmapped");
        chk("out_rst", 0, {boost, sink, clamp, disc, irq});
        hold <= 1'b0;
        cyc(20);
        chk("no_supply", 0, {boost, ss_lim});
        sup <= 1'b1;
        cyc(10);
        chk("ss_start", 3'b111, {ss_lim, sink_ss, clamp});
        for (int s = 0; s < 4; s++)
            run_sel(s);
        above <= 4'hB;
        output_overvoltage_trip <= 1'b1;
        cyc(8);
        chk("lock", 4'h4, rlock);
        output_overvoltage_trip <= 1'b0;
        pulse(100);
        cyc(110);
        chk("lock_kept", 4'h4, rlock);
        above <= 4'hE;
        output_overvoltage_trip <= 1'b1;
        cyc(8);
        chk("retest", 4'h1, rlock);
        output_overvoltage_trip <= 1'b0;
        above <= 4'hF;
        for (int k = 0; k < 3; k++)
        begin
            shut();
            cyc(320);
            chk("active", 5'h1F, {boost, sink});
            flt <= 3'(1 << k);
            cyc(8);
            flt <= 3'h0;
            cyc(8);
            chk("latched", 0, {boost, sink});
            wr_reg(A_IRQ_EN, 32'(4 << k));
            cyc(2);
            chk("irq_on", 1, irq);
            wr_reg(A_IRQ_EN, 32'h0);
            cyc(2);
            chk("irq_mask", 0, irq);
            wr_reg(A_IRQ_EN, 32'(4 << k));
            wr_reg(A_IRQ_CLR, 32'(4 << k));
            cyc(2);
            chk("irq_clr", 0, irq);
        end
        shut();
        cyc(320);
        doc <= 1'b1;
        cyc(8);
        chk("disc_off", 2'b01, {disc, boost});
        d3v <= 1'b1;
        cyc(8);
        chk("boost_off", 0, boost);
        lock <= 1'b1;
        cyc(8);
        chk("comp_lock", 5'h01, {sink, clamp});
        lock <= 1'b0;
        above <= 4'h0;
        cgnd <= 1'b1;
        cyc(8);
        chk("resoft", 3'b110, {ss_lim, sink_ss, disc});
        {doc, d3v, cgnd} <= 3'h0;
        shut();
        cyc(10);
        chk("disc_back", 1, disc);
        summarize();
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            num_errors++;
            summarize();
        end
    end
endmodule : tb_top
